// [logic/ucs_fifo.sv]
// Byte FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/1ps
`default_nettype none

module ucs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Fill side
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  // Drain side
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);

  // DEPTH must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ucs_fifo_state_t;

  ucs_fifo_state_t s;
  ucs_fifo_state_t next_s;
  logic full;
  logic empty;

  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = (s.wp == s.rp);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (wr_valid_in && !full) begin
      next_s.mem[s.wp[AW-1:0]] = wr_data_in;
      next_s.wp = s.wp + 1'b1;
    end
    if (rd_ready_in && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// [logic/ucs_map.svh]
// Constants for the composite suspend controller: offsets, timings, sizes
`ifndef UCS_MAP_SVH
`define UCS_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define UCS_CLK_MHZ 40
`define UCS_SUSPEND_IDLE_US 3000
`define UCS_WAKE_DRIVE_US 2000
`define UCS_SUSPEND_IDLE_CYCLES (`UCS_SUSPEND_IDLE_US * `UCS_CLK_MHZ)
`define UCS_WAKE_DRIVE_CYCLES (`UCS_WAKE_DRIVE_US * `UCS_CLK_MHZ)
`define UCS_TIMER_W 17

// ****************************************
// Buffers and storage
// ****************************************
`define UCS_UART_BUF_DEPTH 64
`define UCS_UART_BUF_TOTAL 128
`define UCS_BYTE_W 8
`define UCS_DESC_DEPTH 64
`define UCS_DESC_AW 6

// ****************************************
// Endpoints and descriptor offsets
// ****************************************
`define UCS_EP_CDC_DATA 4'h2
`define UCS_EP_HID 4'h3
`define UCS_DESC_VID_LO 6'h00
`define UCS_DESC_VID_HI 6'h01
`define UCS_DESC_PID_LO 6'h02
`define UCS_DESC_PID_HI 6'h03

`endif

// [logic/ucs_pkg.sv]
// Types for the composite suspend controller
package ucs_pkg;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_WAKE = 2'b10
  } ucs_link_state_t;

  typedef enum logic [1:0] {
    IF_NONE = 2'b00,
    IF_CDC = 2'b01,
    IF_HID = 2'b10
  } ucs_iface_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_POS = 2'b01,
    EDGE_NEG = 2'b10,
    EDGE_BOTH = 2'b11
  } ucs_edge_sel_t;

endpackage

// [logic/ucs_suspend_ctrl.sv]
// Composite USB function: CDC/HID routing, UART buffers, descriptors, suspend control
// Contract
// - Routes traffic as one composite function: CDC endpoint to UART, HID endpoint aside.
// - UART path buffered by 64-byte transmit and 64-byte receive buffers.
// - Host writes descriptor bytes, including vendor and product ids, into local storage.
// - Suspend state is entered when suspend signalling is seen on the bus.
// - Suspend ends on observed resume or on self-driven remote wake-up.
// - Suspend ends when a bus reset is detected.
// - Suspend ends on any device-level reset.
// - Data-line pull-up stays enabled during suspend.
// - Remote wake-up only from the edge detector on general pin one.
// - Suspend indicator follows state, default active low while suspended.
// - Configured indicator low after reset, high when configured, low in suspend.
`timescale 1ns/1ps
`default_nettype none
`include "ucs_map.svh"

module ucs_suspend_ctrl #(
  parameter logic [`UCS_TIMER_W-1:0] SUSPEND_IDLE_CYCLES =
    `UCS_TIMER_W'(`UCS_SUSPEND_IDLE_CYCLES),
  parameter logic [`UCS_TIMER_W-1:0] WAKE_DRIVE_CYCLES =
    `UCS_TIMER_W'(`UCS_WAKE_DRIVE_CYCLES)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus line events from transceiver (asynchronous levels, double-registered); configured strobe sampled directly
  input wire logic bus_activity_in,
  input wire logic bus_reset_in,
  input wire logic resume_in,
  input wire logic host_configured_in,
  // Host OUT data
  input wire logic host_valid_in,
  input wire logic [3:0] host_ep_in,
  input wire logic [`UCS_BYTE_W-1:0] host_data_in,
  output logic host_ready_out,
  output logic hid_valid_out,
  output logic [`UCS_BYTE_W-1:0] hid_data_out,
  // UART transmit side
  output logic uart_tx_valid_out,
  output logic [`UCS_BYTE_W-1:0] uart_tx_data_out,
  input wire logic uart_tx_ready_in,
  // UART receive side and CDC IN data
  input wire logic uart_rx_valid_in,
  input wire logic [`UCS_BYTE_W-1:0] uart_rx_data_in,
  output logic uart_rx_ready_out,
  output logic cdc_in_valid_out,
  output logic [`UCS_BYTE_W-1:0] cdc_in_data_out,
  input wire logic cdc_in_ready_in,
  // Descriptor storage
  input wire logic desc_wr_en_in,
  input wire logic [`UCS_DESC_AW-1:0] desc_addr_in,
  input wire logic [`UCS_BYTE_W-1:0] desc_wr_data_in,
  output logic [`UCS_BYTE_W-1:0] desc_rd_data_out,
  output logic [15:0] vid_out,
  output logic [15:0] pid_out,
  // Remote wake-up
  input wire logic general_pin_one_in,
  input wire logic [1:0] wake_edge_sel_in,
  input wire logic wake_flag_clear_in,
  input wire logic remote_wake_en_in,
  output logic wake_flag_out,
  output logic resume_drive_out,
  // Indicator pins and line control
  input wire logic suspend_ind_en_in,
  input wire logic suspend_active_high_in,
  input wire logic cfg_ind_en_in,
  output logic suspend_indicator_pin_out,
  output logic suspend_indicator_pin_oe_out,
  output logic configured_indicator_pin_out,
  output logic configured_indicator_pin_oe_out,
  output logic pullup_enable_out,
  output logic suspended_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ucs_pkg::ucs_link_state_t state;
    logic [`UCS_TIMER_W-1:0] idle_cnt;
    logic [`UCS_TIMER_W-1:0] wake_cnt;
    logic configured;
    logic wake_flag;
    logic gp1_meta;
    logic gp1_sync;
    logic gp1_prev;
    logic act_meta;
    logic act_sync;
    logic rst_meta;
    logic rst_sync;
    logic res_meta;
    logic res_sync;
    logic hid_valid;
    logic [`UCS_BYTE_W-1:0] hid_data;
    logic [`UCS_DESC_DEPTH-1:0][`UCS_BYTE_W-1:0] desc_mem;
    logic [`UCS_BYTE_W-1:0] desc_rd;
    logic susp_pin;
    logic cfg_pin;
  } ucs_ctrl_state_t;

  ucs_ctrl_state_t s;
  ucs_ctrl_state_t next_s;
  logic tx_wr_ready;
  logic rise;
  logic fall;
  logic edge_hit;
  logic bus_busy;
  logic next_suspended;

  function automatic ucs_pkg::ucs_iface_t ucs_ep_kind(input logic [3:0] ep);
    if (ep == `UCS_EP_CDC_DATA) begin
      return ucs_pkg::IF_CDC;
    end else if (ep == `UCS_EP_HID) begin
      return ucs_pkg::IF_HID;
    end
    return ucs_pkg::IF_NONE;
  endfunction

  // ****************************************
  // UART buffers
  // ****************************************
  ucs_fifo #(.WIDTH(`UCS_BYTE_W), .DEPTH(`UCS_UART_BUF_DEPTH)) u_tx_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_valid_in(host_valid_in && (ucs_ep_kind(host_ep_in) == ucs_pkg::IF_CDC)),
    .wr_data_in(host_data_in),
    .wr_ready_out(tx_wr_ready),
    .rd_valid_out(uart_tx_valid_out),
    .rd_data_out(uart_tx_data_out),
    .rd_ready_in(uart_tx_ready_in)
  );

  ucs_fifo #(.WIDTH(`UCS_BYTE_W), .DEPTH(`UCS_UART_BUF_DEPTH)) u_rx_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_valid_in(uart_rx_valid_in),
    .wr_data_in(uart_rx_data_in),
    .wr_ready_out(uart_rx_ready_out),
    .rd_valid_out(cdc_in_valid_out),
    .rd_data_out(cdc_in_data_out),
    .rd_ready_in(cdc_in_ready_in)
  );

  // Back-pressure only on the CDC path; HID bytes are always taken
  assign host_ready_out = (ucs_ep_kind(host_ep_in) == ucs_pkg::IF_CDC) ? tx_wr_ready : 1'b1;

  // ****************************************
  // Next state
  // ****************************************
  assign rise = s.gp1_sync && !s.gp1_prev;
  assign fall = !s.gp1_sync && s.gp1_prev;
  assign edge_hit = (wake_edge_sel_in[0] && rise) || (wake_edge_sel_in[1] && fall);
  assign bus_busy = s.act_sync || s.rst_sync || s.res_sync;

  always_comb begin
    next_s = s;
    next_s.gp1_meta = general_pin_one_in;
    next_s.gp1_sync = s.gp1_meta;
    next_s.gp1_prev = s.gp1_sync;
    next_s.act_meta = bus_activity_in;
    next_s.act_sync = s.act_meta;
    next_s.rst_meta = bus_reset_in;
    next_s.rst_sync = s.rst_meta;
    next_s.res_meta = resume_in;
    next_s.res_sync = s.res_meta;
    // Edge arriving with a clear still lands in the flag
    if (wake_flag_clear_in) begin
      next_s.wake_flag = 1'b0;
    end
    if (edge_hit) begin
      next_s.wake_flag = 1'b1;
    end
    if (host_configured_in) begin
      next_s.configured = 1'b1;
    end
    if (s.rst_sync) begin
      next_s.configured = 1'b0;
    end
    next_s.hid_valid = host_valid_in && (ucs_ep_kind(host_ep_in) == ucs_pkg::IF_HID);
    if (next_s.hid_valid) begin
      next_s.hid_data = host_data_in;
    end
    if (desc_wr_en_in) begin
      next_s.desc_mem[desc_addr_in] = desc_wr_data_in;
    end
    next_s.desc_rd = s.desc_mem[desc_addr_in];
    if (bus_busy) begin
      next_s.idle_cnt = '0;
    end else if (s.idle_cnt != SUSPEND_IDLE_CYCLES) begin
      next_s.idle_cnt = s.idle_cnt + 1'b1;
    end
    unique case (s.state)
      ucs_pkg::ST_ACTIVE: begin
        if (!bus_busy && s.idle_cnt == SUSPEND_IDLE_CYCLES - 1'b1) begin
          next_s.state = ucs_pkg::ST_SUSPEND;
        end
      end
      ucs_pkg::ST_SUSPEND: begin
        if (s.rst_sync || s.res_sync) begin
          next_s.state = ucs_pkg::ST_ACTIVE;
        end else if (edge_hit && remote_wake_en_in) begin
          next_s.state = ucs_pkg::ST_WAKE;
          next_s.wake_cnt = '0;
        end
      end
      ucs_pkg::ST_WAKE: begin
        next_s.idle_cnt = '0;
        next_s.wake_cnt = s.wake_cnt + 1'b1;
        if (s.rst_sync || s.wake_cnt == WAKE_DRIVE_CYCLES - 1'b1) begin
          next_s.state = ucs_pkg::ST_ACTIVE;
        end
      end
      default: begin
        next_s.state = ucs_pkg::ST_ACTIVE;
      end
    endcase
    next_suspended = (next_s.state == ucs_pkg::ST_SUSPEND);
    next_s.susp_pin = next_suspended ? suspend_active_high_in : !suspend_active_high_in;
    next_s.cfg_pin = next_s.configured && !next_suspended;
  end

  // Reset returns to the active state, so suspend always ends here
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hid_valid_out = s.hid_valid;
  assign hid_data_out = s.hid_data;
  assign desc_rd_data_out = s.desc_rd;
  assign vid_out = {s.desc_mem[`UCS_DESC_VID_HI], s.desc_mem[`UCS_DESC_VID_LO]};
  assign pid_out = {s.desc_mem[`UCS_DESC_PID_HI], s.desc_mem[`UCS_DESC_PID_LO]};
  assign wake_flag_out = s.wake_flag;
  assign resume_drive_out = (s.state == ucs_pkg::ST_WAKE);
  assign suspended_out = (s.state == ucs_pkg::ST_SUSPEND);
  assign suspend_indicator_pin_out = s.susp_pin;
  assign suspend_indicator_pin_oe_out = suspend_ind_en_in;
  assign configured_indicator_pin_out = s.cfg_pin;
  assign configured_indicator_pin_oe_out = cfg_ind_en_in;
  // Host must keep seeing the device attached, suspended or not
  assign pullup_enable_out = 1'b1;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_hid_route;
    host_valid_in && host_ep_in == `UCS_EP_HID |=> hid_valid_out && hid_data_out == $past(host_data_in);
  endproperty
  a_hid_route: assert property (p_hid_route) else $error("HID byte not routed");

  property p_desc_keep;
    desc_wr_en_in ##1 (!desc_wr_en_in && desc_addr_in == $past(desc_addr_in))
      |=> desc_rd_data_out == $past(desc_wr_data_in, 2);
  endproperty
  a_desc_keep: assert property (p_desc_keep) else $error("Descriptor byte lost");

  property p_enter_suspend;
    s.state == ucs_pkg::ST_ACTIVE && !bus_busy && s.idle_cnt == SUSPEND_IDLE_CYCLES - 1'b1
      |=> suspended_out;
  endproperty
  a_enter_suspend: assert property (p_enter_suspend) else $error("No suspend after idle");

  property p_no_early_suspend;
    $rose(suspended_out) |-> $past(s.idle_cnt) == SUSPEND_IDLE_CYCLES - 1'b1;
  endproperty
  a_no_early_suspend: assert property (p_no_early_suspend) else $error("Suspend too early");

  property p_resume_exit;
    suspended_out && s.res_sync |=> s.state == ucs_pkg::ST_ACTIVE;
  endproperty
  a_resume_exit: assert property (p_resume_exit) else $error("Resume did not exit");

  property p_bus_reset_exit;
    s.rst_sync |=> s.state == ucs_pkg::ST_ACTIVE && !s.configured;
  endproperty
  a_bus_reset_exit: assert property (p_bus_reset_exit) else $error("Bus reset ignored");

  property p_dev_reset_exit;
    $fell(sys_rst_in) |-> !suspended_out && !resume_drive_out;
  endproperty
  a_dev_reset_exit: assert property (p_dev_reset_exit) else $error("Reset left suspend");

  property p_pullup;
    suspended_out |-> pullup_enable_out;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up dropped");

  property p_wake_source;
    $rose(resume_drive_out) |-> $past(edge_hit) && $past(remote_wake_en_in);
  endproperty
  a_wake_source: assert property (p_wake_source) else $error("Wake without pin edge");

  property p_wake_hold;
    $rose(resume_drive_out) && !s.rst_sync |-> resume_drive_out[*2];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("Resume drive cut short");

  property p_susp_pin;
    suspended_out && !$past(suspend_active_high_in) |-> !suspend_indicator_pin_out;
  endproperty
  a_susp_pin: assert property (p_susp_pin) else $error("Suspend pin level wrong");

  property p_cfg_pin;
    suspended_out |-> !configured_indicator_pin_out;
  endproperty
  a_cfg_pin: assert property (p_cfg_pin) else $error("Configured pin high in suspend");

  property p_idle_restart;
    s.act_sync |=> s.idle_cnt == '0;
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("Idle timer not restarted");

endmodule

`default_nettype wire

// [verification/test_ucs_suspend_ctrl.sv]
// Self-checking bench for the composite suspend controller
`timescale 1ns/1ps
`default_nettype none

module test_ucs_suspend_ctrl;
  // Short counts keep the run brief
  localparam int IDLE_N = 40;
  localparam int WAKE_N = 10;
  typedef struct packed {
    logic [3:0] ep;
    logic [7:0] data;
    logic hid;
    logic tx;
  } ucs_row_t;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic bus_activity_in, bus_reset_in, resume_in, host_configured_in, host_valid_in;
  logic host_ready_out, hid_valid_out, uart_tx_valid_out, uart_tx_ready_in, uart_rx_valid_in;
  logic uart_rx_ready_out, cdc_in_valid_out, cdc_in_ready_in, desc_wr_en_in;
  logic general_pin_one_in, wake_flag_clear_in, remote_wake_en_in, wake_flag_out;
  logic resume_drive_out, suspend_ind_en_in, suspend_active_high_in, cfg_ind_en_in;
  logic suspend_indicator_pin_out, suspend_indicator_pin_oe_out, configured_indicator_pin_out;
  logic configured_indicator_pin_oe_out, pullup_enable_out, suspended_out;
  logic [3:0] host_ep_in;
  logic [1:0] wake_edge_sel_in;
  logic [5:0] desc_addr_in;
  logic [7:0] host_data_in, hid_data_out, uart_tx_data_out, uart_rx_data_in, cdc_in_data_out;
  logic [7:0] desc_wr_data_in, desc_rd_data_out;
  logic [15:0] vid_out, pid_out;
  int fails = 0;
  int total_checks = 0;
  ucs_row_t rows [4] = '{'{4'h2, 8'hA5, 1'b0, 1'b1}, '{4'h3, 8'h3C, 1'b1, 1'b0},
    '{4'h5, 8'h77, 1'b0, 1'b0}, '{4'h2, 8'h5A, 1'b0, 1'b1}};

  ucs_suspend_ctrl #(.SUSPEND_IDLE_CYCLES(17'h0_0028), .WAKE_DRIVE_CYCLES(17'h0_000A))
    ucs_suspend_ctrl_inst (.clk_in, .sys_rst_in, .bus_activity_in, .bus_reset_in, .resume_in,
    .host_configured_in, .host_valid_in, .host_ep_in, .host_data_in, .host_ready_out,
    .hid_valid_out, .hid_data_out, .uart_tx_valid_out, .uart_tx_data_out, .uart_tx_ready_in,
    .uart_rx_valid_in, .uart_rx_data_in, .uart_rx_ready_out, .cdc_in_valid_out,
    .cdc_in_data_out, .cdc_in_ready_in, .desc_wr_en_in, .desc_addr_in, .desc_wr_data_in,
    .desc_rd_data_out, .vid_out, .pid_out, .general_pin_one_in, .wake_edge_sel_in,
    .wake_flag_clear_in, .remote_wake_en_in, .wake_flag_out, .resume_drive_out,
    .suspend_ind_en_in, .suspend_active_high_in, .cfg_ind_en_in, .suspend_indicator_pin_out,
    .suspend_indicator_pin_oe_out, .configured_indicator_pin_out,
    .configured_indicator_pin_oe_out, .pullup_enable_out, .suspended_out);

  ucs_host_model ucs_host_model_inst (.clk_in, .bus_activity_out(bus_activity_in),
    .bus_reset_out(bus_reset_in), .resume_out(resume_in), .host_configured_out(host_configured_in),
    .host_valid_out(host_valid_in), .host_ep_out(host_ep_in), .host_data_out(host_data_in),
    .host_ready_in(host_ready_out), .desc_wr_en_out(desc_wr_en_in),
    .desc_addr_out(desc_addr_in), .desc_wr_data_out(desc_wr_data_in));

  always #12.5 clk_in = ~clk_in;

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // Bounded wait on the suspend level or the wake drive
  task automatic wait_on(input logic drv, input logic lvl, input int lim);
    for (int k = 0; k < lim; k++) begin
      if ((drv ? resume_drive_out : suspended_out) === lvl) break;
      tick(1);
    end
    chk(drv ? resume_drive_out : suspended_out, lvl);
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #100_000;
    fails++;
    summarize();
  end

  // ****
  // Sequence
  // ****
  initial begin
    logic [7:0] q [$];
    {uart_tx_ready_in, uart_rx_valid_in, cdc_in_ready_in, general_pin_one_in} = 4'h0;
    {wake_flag_clear_in, remote_wake_en_in, suspend_active_high_in} = 3'h0;
    {suspend_ind_en_in, cfg_ind_en_in, wake_edge_sel_in} = 4'hD;
    uart_rx_data_in = 8'h00;
    tick(10);
    sys_rst_in = 1'b0;
    tick(1);
    chk(suspend_indicator_pin_out, 1'b1);
    chk(configured_indicator_pin_out, 1'b0);
    chk(pullup_enable_out, 1'b1);
    chk(suspend_indicator_pin_oe_out, 1'b1);
    chk(configured_indicator_pin_oe_out, 1'b1);
    ucs_host_model_inst.line(1'b1, 1'b0, 1'b0);
    foreach (rows[i]) begin
      ucs_host_model_inst.send(rows[i].ep, rows[i].data);
      chk(hid_valid_out, rows[i].hid);
      if (rows[i].hid) chk(hid_data_out, rows[i].data);
      if (rows[i].tx) q.push_back(rows[i].data);
    end
    ucs_host_model_inst.stop();
    uart_tx_ready_in = 1'b1;
    foreach (q[i]) begin
      chk({uart_tx_valid_out, uart_tx_data_out}, {1'b1, q[i]});
      tick(1);
    end
    uart_tx_ready_in = 1'b0;
    chk(uart_tx_valid_out, 1'b0);
    ucs_host_model_inst.desc(6'h00, 8'h34);
    ucs_host_model_inst.desc(6'h01, 8'h12);
    ucs_host_model_inst.desc(6'h02, 8'h78);
    ucs_host_model_inst.desc(6'h03, 8'h56);
    ucs_host_model_inst.desc(6'h3F, 8'hC3);
    tick(1);
    chk(desc_rd_data_out, 8'hC3);
    chk(vid_out, 16'h1234);
    chk(pid_out, 16'h5678);
    // Both buffers filled in lockstep, then drained with stalls
    for (int i = 0; i < 64; i++) begin
      uart_rx_valid_in = 1'b1;
      uart_rx_data_in = 8'(i + 64);
      ucs_host_model_inst.send(4'h2, 8'(i));
    end
    chk(host_ready_out, 1'b0);
    chk(uart_rx_ready_out, 1'b0);
    ucs_host_model_inst.stop();
    uart_rx_valid_in = 1'b0;
    for (int i = 0; i < 64; i++) begin
      chk({uart_tx_valid_out, uart_tx_data_out}, {1'b1, 8'(i)});
      chk({cdc_in_valid_out, cdc_in_data_out}, {1'b1, 8'(i + 64)});
      {uart_tx_ready_in, cdc_in_ready_in} = 2'h3;
      tick(1);
      {uart_tx_ready_in, cdc_in_ready_in} = 2'h0;
      tick(1);
    end
    chk({uart_tx_valid_out, cdc_in_valid_out}, 2'h0);
    ucs_host_model_inst.configure();
    tick(1);
    chk(configured_indicator_pin_out, 1'b1);
    // Idle cut short by one activity cycle must restart the count
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b0);
    tick(IDLE_N - 10);
    ucs_host_model_inst.line(1'b1, 1'b0, 1'b0);
    tick(1);
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b0);
    tick(IDLE_N - 5);
    chk(suspended_out, 1'b0);
    wait_on(1'b0, 1'b1, 20);
    tick(2);
    chk(suspend_indicator_pin_out, 1'b0);
    chk(configured_indicator_pin_out, 1'b0);
    chk(pullup_enable_out, 1'b1);
    ucs_host_model_inst.line(1'b1, 1'b0, 1'b0);
    tick(1);
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b0);
    tick(5);
    chk(suspended_out, 1'b1);
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b1);
    wait_on(1'b0, 1'b0, 6);
    tick(2);
    chk(suspend_indicator_pin_out, 1'b1);
    chk(configured_indicator_pin_out, 1'b1);
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b0);
    wait_on(1'b0, 1'b1, IDLE_N + 10);
    ucs_host_model_inst.line(1'b0, 1'b1, 1'b0);
    wait_on(1'b0, 1'b0, 6);
    chk(configured_indicator_pin_out, 1'b0);
    // Active-high indicator polarity for this suspend only
    suspend_active_high_in = 1'b1;
    ucs_host_model_inst.line(1'b0, 1'b0, 1'b0);
    wait_on(1'b0, 1'b1, IDLE_N + 10);
    chk(suspend_indicator_pin_out, 1'b1);
    suspend_active_high_in = 1'b0;
    sys_rst_in = 1'b1;
    tick(2);
    chk(suspended_out, 1'b0);
    sys_rst_in = 1'b0;
    tick(1);
    chk(suspend_indicator_pin_out, 1'b1);
    // Pin edge without host permission only marks the flag
    wait_on(1'b0, 1'b1, IDLE_N + 10);
    general_pin_one_in = 1'b1;
    tick(8);
    chk(suspended_out, 1'b1);
    chk(wake_flag_out, 1'b1);
    wake_flag_clear_in = 1'b1;
    tick(1);
    wake_flag_clear_in = 1'b0;
    tick(1);
    chk(wake_flag_out, 1'b0);
    {remote_wake_en_in, wake_edge_sel_in} = 3'h6;
    general_pin_one_in = 1'b0;
    wait_on(1'b1, 1'b1, 6);
    chk(suspended_out, 1'b0);
    wait_on(1'b1, 1'b0, WAKE_N + 5);
    chk(suspended_out, 1'b0);
    summarize();
  end
endmodule

`default_nettype wire

// [verification/ucs_host_model.sv]
// Host controller model: bus line levels, OUT bytes, descriptor writes
`timescale 1ns/1ps
`default_nettype none

module ucs_host_model (
  // Clock
  input wire logic clk_in,
  // Bus line levels
  output logic bus_activity_out,
  output logic bus_reset_out,
  output logic resume_out,
  output logic host_configured_out,
  // OUT data
  output logic host_valid_out,
  output logic [3:0] host_ep_out,
  output logic [7:0] host_data_out,
  input wire logic host_ready_in,
  // Descriptor writes
  output logic desc_wr_en_out,
  output logic [5:0] desc_addr_out,
  output logic [7:0] desc_wr_data_out
);
  // ****
  // Host actions, all called just after a rising edge
  // ****
  initial begin
    {bus_activity_out, bus_reset_out, resume_out, host_configured_out} = 4'h0;
    {host_valid_out, host_ep_out, host_data_out} = 13'h0_000;
    {desc_wr_en_out, desc_addr_out, desc_wr_data_out} = 15'h0_000;
  end
  // A long all-low stretch is how the host asks for suspend
  task automatic line(input logic act, input logic rst, input logic res);
    {bus_activity_out, bus_reset_out, resume_out} = {act, rst, res};
  endtask
  // Byte held until ready is seen at an edge; valid left up for bursts
  task automatic send(input logic [3:0] ep, input logic [7:0] d);
    logic rdy;
    host_valid_out = 1'b1;
    host_ep_out = ep;
    host_data_out = d;
    do begin
      @(negedge clk_in) rdy = host_ready_in;
      @(posedge clk_in);
      #2;
    end while (!rdy);
  endtask
  // Released data never shows the stale byte
  task automatic stop();
    host_valid_out = 1'b0;
    host_data_out = ~host_data_out;
  endtask
  task automatic desc(input logic [5:0] a, input logic [7:0] d);
    {desc_wr_en_out, desc_addr_out, desc_wr_data_out} = {1'b1, a, d};
    @(posedge clk_in);
    #2;
    desc_wr_en_out = 1'b0;
    desc_wr_data_out = ~d;
    // One idle edge, so the next write never re-raises the strobe in this step
    @(posedge clk_in);
    #2;
  endtask
  task automatic configure();
    host_configured_out = 1'b1;
    @(posedge clk_in);
    #2;
    host_configured_out = 1'b0;
  endtask
endmodule

`default_nettype wire
